// [src/otp_prog_ecc.sv]
// otp page programming control and ecc self-test with axi4-lite registers
// Overview of operation
// - page_select 0 programs page one, 1 page two
// - writing program_trigger 1 starts programming; 0 ready
// - trigger honoured only after both unlock keys
// - keys written bytes a to d; read zero
// - self-test outcome lands in nine result bytes
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "otp_map.svh"
module otp_prog_ecc
  import otp_pkg::*;
#(
  parameter logic [31:0] KEY1 = `OTP_KEY1_CODE,
  parameter logic [31:0] KEY2 = `OTP_KEY2_CODE
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // axi4-lite write channels
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read channels
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // otp array programming
  output logic o_prog_start,
  output logic o_prog_page,
  input wire logic i_prog_done,
  // normal otp read path
  input wire logic [71:0] i_otp_word,
  input wire logic i_otp_valid,
  output logic [63:0] o_otp_data,
  // interrupt
  output logic o_irq
);
  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic aw_full;
  logic w_full;
  logic [`OTP_IDX_W-1:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_strb;
  logic wr_fire;
  logic wr_en;
  logic [`OTP_IDX_W-1:0] rd_idx;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  assign o_awready = ~aw_full;
  assign o_wready = ~w_full;
  assign o_arready = ~o_rvalid;
  assign wr_fire = aw_full & w_full & ~o_bvalid;
  assign wr_en = wr_fire & wr_strb;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_idx <= '0;
      wr_byte <= `OTP_BYTE_RST;
      wr_strb <= 1'b0;
    end else begin
      if (i_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        wr_idx <= i_awaddr[`OTP_IDX_W+1:2];
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (i_wvalid && !w_full) begin
        w_full <= 1'b1;
        wr_byte <= i_wdata[7:0];
        wr_strb <= i_wstrb[0];
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_bvalid <= 1'b0;
      o_bresp <= `OTP_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_ok ? `OTP_RESP_OKAY : `OTP_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= `OTP_RESP_OKAY;
      rd_idx <= '0;
    end else if (i_arvalid && !o_rvalid) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_val;
      o_rresp <= rd_ok ? `OTP_RESP_OKAY : `OTP_RESP_SLVERR;
      rd_idx <= i_araddr[`OTP_IDX_W+1:2];
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // unlock keys
  // ****************************************************************
  logic [2:0] key1_step;
  logic [2:0] key2_step;
  logic unlocked;
  logic hit_key1;
  logic hit_key2;
  logic trig_wr;
  logic accept;
  otp_state_type state;

  assign hit_key1 = wr_idx >= `OTP_IDX_KEY1A && wr_idx <= `OTP_IDX_KEY1D;
  assign hit_key2 = wr_idx >= `OTP_IDX_KEY2A && wr_idx <= `OTP_IDX_KEY2D;
  assign unlocked = key1_step == `OTP_KEY_DONE && key2_step == `OTP_KEY_DONE;
  assign trig_wr = wr_en && wr_idx == `OTP_IDX_CTRL && wr_byte[`OTP_CTRL_GO];
  assign accept = trig_wr && unlocked && state == OTP_IDLE;

  // a wrong byte, a skipped byte or a write outside both key ranges starts over
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      key1_step <= '0;
      key2_step <= '0;
    end else if (wr_en) begin
      if (hit_key1) begin
        key1_step <= (wr_idx == `OTP_IDX_KEY1A + 12'(key1_step) &&
          wr_byte == KEY1[8*(3-key1_step[1:0]) +: 8]) ?
          key1_step + 3'h1 : 3'h0;
      end else if (hit_key2) begin
        key2_step <= (wr_idx == `OTP_IDX_KEY2A + 12'(key2_step) &&
          wr_byte == KEY2[8*(3-key2_step[1:0]) +: 8]) ?
          key2_step + 3'h1 : 3'h0;
      end else begin
        key1_step <= '0;
        key2_step <= '0;
      end
    end
  end

  // ****************************************************************
  // programming control
  // ****************************************************************
  logic page_select;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      page_select <= 1'b0;
    end else if (wr_en && wr_idx == `OTP_IDX_CTRL && state == OTP_IDLE) begin
      page_select <= wr_byte[`OTP_CTRL_PAGE];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state <= OTP_IDLE;
      o_prog_start <= 1'b0;
      o_prog_page <= 1'b0;
    end else begin
      o_prog_start <= accept;
      case (state)
        OTP_IDLE: begin
          if (accept) begin
            state <= OTP_PROG;
            o_prog_page <= wr_byte[`OTP_CTRL_PAGE];
          end
        end
        OTP_PROG: begin
          if (i_prog_done) begin
            state <= OTP_IDLE;
          end
        end
        default: begin
          state <= OTP_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // ecc self-test
  // ****************************************************************
  otp_byte_type test_in [`OTP_NBYTES];
  otp_byte_type test_out [`OTP_NBYTES];
  logic [3:0] test_ctrl;
  logic [71:0] coder_in;
  logic [71:0] coder_out;
  logic coder_enc;
  logic coder_sec;
  logic coder_ded;
  logic ecc_en;

  assign ecc_en = test_ctrl[`OTP_TEST_EN];
  // disabled test leaves the coder on the live otp word
  assign coder_in = ecc_en ? {test_in[8], test_in[7], test_in[6],
    test_in[5], test_in[4], test_in[3], test_in[2], test_in[1],
    test_in[0]} : i_otp_word;
  assign coder_enc = ecc_en & test_ctrl[`OTP_TEST_DIR];

  otp_ecc_coder #(
    .DATA_W(64)
  ) u_coder (
    .i_word(coder_in),
    .i_encode(coder_enc),
    .o_result(coder_out),
    .o_sec(coder_sec),
    .o_ded(coder_ded)
  );

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      test_ctrl <= `OTP_TEST_RST;
      for (int i = 0; i < `OTP_NBYTES; i++) begin
        test_in[i] <= `OTP_BYTE_RST;
      end
    end else if (wr_en) begin
      if (wr_idx == `OTP_IDX_TEST) begin
        test_ctrl <= wr_byte[3:0];
      end
      if (wr_idx >= `OTP_IDX_DIN1 && wr_idx <= `OTP_IDX_DIN9) begin
        test_in[4'(wr_idx - `OTP_IDX_DIN1)] <= wr_byte;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < `OTP_NBYTES; i++) begin
        test_out[i] <= `OTP_BYTE_RST;
      end
    end else if (ecc_en) begin
      for (int i = 0; i < `OTP_NBYTES; i++) begin
        test_out[i] <= coder_out[8*i +: 8];
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_otp_data <= '0;
    end else if (i_otp_valid && !ecc_en) begin
      o_otp_data <= coder_out[63:0];
    end
  end

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  logic [3:0] ev_stat;
  logic [3:0] ev_en;
  logic [3:0] ev_set;
  logic test_sec;
  logic test_ded;

  // the fault class picks which detection the test may raise
  assign test_sec = ecc_en & ~test_ctrl[`OTP_TEST_CLASS] & coder_sec;
  assign test_ded = ecc_en & test_ctrl[`OTP_TEST_CLASS] & coder_ded;
  assign ev_set[`OTP_EV_DONE] = state == OTP_PROG && i_prog_done;
  assign ev_set[`OTP_EV_REFUSED] = trig_wr && !unlocked;
  assign ev_set[`OTP_EV_SEC] = test_sec | (i_otp_valid & ~ecc_en & coder_sec);
  assign ev_set[`OTP_EV_DED] = test_ded | (i_otp_valid & ~ecc_en & coder_ded);

  // a set in the clearing cycle wins
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ev_stat <= `OTP_EV_RST;
      ev_en <= `OTP_EV_RST;
    end else begin
      if (wr_en && wr_idx == `OTP_IDX_IRQ_CLR) begin
        ev_stat <= (ev_stat & ~wr_byte[3:0]) | ev_set;
      end else begin
        ev_stat <= ev_stat | ev_set;
      end
      if (wr_en && wr_idx == `OTP_IDX_IRQ_EN) begin
        ev_en <= wr_byte[3:0];
      end
    end
  end

  assign o_irq = |(ev_stat & ev_en);

  // ****************************************************************
  // read mux and write map
  // ****************************************************************
  logic [`OTP_IDX_W-1:0] ar_idx;

  assign ar_idx = i_araddr[`OTP_IDX_W+1:2];
  assign wr_ok = hit_key1 || hit_key2 || wr_idx == `OTP_IDX_CTRL ||
    wr_idx == `OTP_IDX_TEST || wr_idx == `OTP_IDX_IRQ_CLR ||
    wr_idx == `OTP_IDX_IRQ_EN ||
    (wr_idx >= `OTP_IDX_DIN1 && wr_idx <= `OTP_IDX_DIN9);

  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    if (ar_idx >= `OTP_IDX_DIN1 && ar_idx <= `OTP_IDX_DIN9) begin
      rd_val[7:0] = test_in[4'(ar_idx - `OTP_IDX_DIN1)];
    end else if (ar_idx >= `OTP_IDX_DOUT1 && ar_idx <= `OTP_IDX_DOUT9) begin
      rd_val[7:0] = test_out[4'(ar_idx - `OTP_IDX_DOUT1)];
    end else begin
      case (ar_idx)
        `OTP_IDX_CTRL: begin
          rd_val[`OTP_CTRL_PAGE] = page_select;
          rd_val[`OTP_CTRL_GO] = state == OTP_PROG;
        end
        `OTP_IDX_TEST: rd_val[3:0] = test_ctrl;
        `OTP_IDX_STAT: rd_val[1:0] = {unlocked, state == OTP_PROG};
        `OTP_IDX_IRQ_ST: rd_val[3:0] = ev_stat;
        `OTP_IDX_IRQ_EN: rd_val[3:0] = ev_en;
        default: begin
          // key registers read zero; clear register is write-only
          rd_ok = (ar_idx >= `OTP_IDX_KEY1A && ar_idx <= `OTP_IDX_KEY1D) ||
            (ar_idx >= `OTP_IDX_KEY2A && ar_idx <= `OTP_IDX_KEY2D) ||
            ar_idx == `OTP_IDX_IRQ_CLR;
        end
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence trig_seq;
    accept;
  endsequence
  // a done pulse right after the start must not trip this
  sequence run_seq;
    (o_prog_start && state == OTP_PROG) ##1 !o_prog_start;
  endsequence

  page_follow_a: assert property (accept |=> o_prog_page ==
    $past(wr_byte[`OTP_CTRL_PAGE])) else $error("page not followed");
  trig_start_a: assert property (trig_seq |=> run_seq)
    else $error("trigger did not start");
  locked_hold_a: assert property (trig_wr && !unlocked &&
    state == OTP_IDLE |=> !o_prog_start ##1 state == OTP_IDLE)
    else $error("locked start");
  start_needs_a: assert property ($rose(o_prog_start) |->
    $past(unlocked)) else $error("start without keys");
  key_zero_a: assert property (o_rvalid && !$past(o_rvalid) &&
    rd_idx >= `OTP_IDX_KEY1A && rd_idx <= `OTP_IDX_KEY1D |->
    o_rdata == 32'h0000_0000) else $error("key read nonzero");
  result_load_a: assert property (ecc_en |=>
    test_out[8] == $past(coder_out[71:64])) else $error("result stale");
  dir_pick_a: assert property (ecc_en && test_ctrl[`OTP_TEST_DIR] |=>
    test_out[0] == $past(test_in[0])) else $error("wrong direction");
  normal_path_a: assert property (!ecc_en && i_otp_valid |=>
    o_otp_data == $past(coder_out[63:0]) && $stable(test_out[0]))
    else $error("normal path disturbed");
endmodule : otp_prog_ecc

// [src/otp_map.svh]
// register indices, field positions, reset values and codes of the otp block
`ifndef OTP_MAP_SVH
`define OTP_MAP_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define OTP_IDX_W 12
`define OTP_IDX_KEY1A 12'h0300
`define OTP_IDX_KEY1D 12'h0303
`define OTP_IDX_CTRL 12'h030B
`define OTP_IDX_DIN1 12'h0343
`define OTP_IDX_DIN9 12'h034B
`define OTP_IDX_TEST 12'h034C
`define OTP_IDX_KEY2A 12'h0352
`define OTP_IDX_KEY2D 12'h0355
`define OTP_IDX_DOUT1 12'h0510
`define OTP_IDX_DOUT9 12'h0518
`define OTP_IDX_STAT 12'h0600
`define OTP_IDX_IRQ_ST 12'h0601
`define OTP_IDX_IRQ_CLR 12'h0602
`define OTP_IDX_IRQ_EN 12'h0603

// ****************************************************************
// field positions
// ****************************************************************
`define OTP_CTRL_GO 0
`define OTP_CTRL_PAGE 1
`define OTP_TEST_EN 0
`define OTP_TEST_DIR 1
`define OTP_TEST_MANUAL 2
`define OTP_TEST_CLASS 3
`define OTP_EV_DONE 0
`define OTP_EV_REFUSED 1
`define OTP_EV_SEC 2
`define OTP_EV_DED 3

// ****************************************************************
// reset values, counts and bus answers
// ****************************************************************
`define OTP_BYTE_RST 8'h00
`define OTP_TEST_RST 4'h0
`define OTP_EV_RST 4'h0
`define OTP_KEY_DONE 3'h4
`define OTP_NBYTES 9
`define OTP_RESP_OKAY 2'b00
`define OTP_RESP_SLVERR 2'b10
// unlock codes: values are arbitrary
`define OTP_KEY1_CODE 32'h1357_9BDF
`define OTP_KEY2_CODE 32'h2468_ACE0

`endif

// [src/otp_pkg.sv]
// types shared by the otp program and ecc test block
package otp_pkg;
  typedef enum logic [0:0] {
    OTP_IDLE = 1'b0,
    OTP_PROG = 1'b1
  } otp_state_type;
  typedef logic [7:0] otp_byte_type;
endpackage : otp_pkg

// [src/otp_ecc_coder.sv]
// sec-ded encoder and decoder for 64 data bits plus 8 check bits
`timescale 1ns/10ps
module otp_ecc_coder
  import otp_pkg::*;
#(
  parameter int DATA_W = 64
) (
  // codeword in and mode
  input wire logic [DATA_W+7:0] i_word,
  input wire logic i_encode,
  // result and detections
  output logic [DATA_W+7:0] o_result,
  output logic o_sec,
  output logic o_ded
);
  // ****************************************************************
  // column code: distinct, never one-hot, so check bits stay apart
  // ****************************************************************
  function automatic logic [6:0] col(input int idx);
    logic [6:0] c;
    c = {1'b1, 6'(idx)};
    if (idx == 0) begin
      c = 7'h03;
    end
    return c;
  endfunction : col

  logic [6:0] calc;
  logic [6:0] syn;
  logic par;
  logic [DATA_W-1:0] fixed;

  always_comb begin
    calc = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (i_word[i]) begin
        calc = calc ^ col(i);
      end
    end
    syn = calc ^ i_word[DATA_W+6:DATA_W];
    par = ^i_word;
    fixed = i_word[DATA_W-1:0];
    for (int i = 0; i < DATA_W; i++) begin
      if (par && (col(i) == syn)) begin
        fixed[i] = ~fixed[i];
      end
    end
  end

  always_comb begin
    if (i_encode) begin
      o_result = {^{calc, i_word[DATA_W-1:0]}, calc, i_word[DATA_W-1:0]};
      o_sec = 1'b0;
      o_ded = 1'b0;
    end else begin
      o_result = {par, syn, fixed};
      o_sec = par;
      // even parity with a nonzero syndrome: two bits flipped
      o_ded = ~par & (syn != 7'h00);
    end
  end
endmodule : otp_ecc_coder

// [tb/tb_otp_prog_ecc.sv]
// self-checking bench of the otp program and ecc test block
`timescale 1ns/10ps
`include "otp_map.svh"
module tb_otp_prog_ecc
  import otp_pkg::*;
;
  localparam logic [63:0] DATA = 64'hA5A5_A5A5_A5A5_A5A5;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [31:0] i_awaddr = 32'h0000_0000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] i_araddr = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic i_prog_done = 1'b0, i_otp_valid = 1'b0;
  logic [71:0] i_otp_word = 72'h00_0000_0000_0000_0000;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic [31:0] o_rdata, rdv;
  logic o_prog_start, o_prog_page, o_irq;
  logic [63:0] o_otp_data;
  int bad_count = 0;
  int samples_checked = 0;
  int starts = 0;

  otp_prog_ecc otp_prog_ecc_i (
    .i_mclk(i_mclk), .i_reset(i_reset),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_prog_start(o_prog_start), .o_prog_page(o_prog_page),
    .i_prog_done(i_prog_done), .i_otp_word(i_otp_word),
    .i_otp_valid(i_otp_valid), .o_otp_data(o_otp_data), .o_irq(o_irq)
  );

  always #25 i_mclk = ~i_mclk;

  // counts accepted programming starts
  always @(posedge i_mclk) begin
    if (o_prog_start === 1'b1) starts++;
  end

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  function automatic logic [7:0] enc9(input logic [63:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 64; i++) begin
      if (d[i]) c ^= (i == 0) ? 7'h03 : {1'b1, 6'(i)};
    end
    return {^d ^ ^c, c};
  endfunction : enc9

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] x, input logic [7:0] d,
                    output logic [1:0] r);
    r = 2'bxx;
    @(posedge i_mclk);
    i_awaddr <= {18'h0_0000, x, 2'h0};
    i_wdata <= {24'h00_0000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge i_mclk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) begin
        r = o_bresp;
        i_bready <= 1'b0;
        return;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] x, output logic [31:0] d,
                    output logic [1:0] r);
    r = 2'bxx;
    d = 32'hxxxx_xxxx;
    @(posedge i_mclk);
    i_araddr <= {18'h0_0000, x, 2'h0};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge i_mclk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) begin
        r = o_rresp;
        d = o_rdata;
        i_rready <= 1'b0;
        return;
      end
    end
  endtask : rd

  task automatic wok(input logic [11:0] x, input logic [7:0] d);
    wr(x, d, rsp);
    chk("bresp", {30'h0, `OTP_RESP_OKAY}, {30'h0, rsp});
  endtask : wok

  task automatic rdx(input logic [11:0] x, input logic [7:0] e,
                     input string n);
    rd(x, rdv, rsp);
    chk("rresp", {30'h0, `OTP_RESP_OKAY}, {30'h0, rsp});
    chk(n, {24'h00_0000, e}, rdv);
  endtask : rdx

  // keys go in highest byte first, register a to d
  task automatic unlock(input logic [31:0] k1, input logic [31:0] k2);
    for (int b = 0; b < 4; b++) wok(`OTP_IDX_KEY1A + 12'(b), k1[31-8*b -: 8]);
    for (int b = 0; b < 4; b++) wok(`OTP_IDX_KEY2A + 12'(b), k2[31-8*b -: 8]);
  endtask : unlock

  task automatic check_pins(input logic e_irq);
    @(negedge i_mclk);
    chk("o_irq", {31'h0, e_irq}, {31'h0, o_irq});
  endtask : check_pins

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rdx(`OTP_IDX_TEST, `OTP_BYTE_RST, "test ctrl reset");
    rdx(`OTP_IDX_DIN1, `OTP_BYTE_RST, "din1 reset");
    rdx(`OTP_IDX_DOUT9, `OTP_BYTE_RST, "dout9 reset");
    rdx(`OTP_IDX_CTRL, 8'h00, "ctrl idle");
    check_pins(1'b0);
  endtask : t_reset

  task automatic t_unmapped();
    wr(12'h0700, 8'h5A, rsp);
    chk("bresp unmapped", {30'h0, `OTP_RESP_SLVERR}, {30'h0, rsp});
    rd(12'h0700, rdv, rsp);
    chk("rresp unmapped", {30'h0, `OTP_RESP_SLVERR}, {30'h0, rsp});
  endtask : t_unmapped

  task automatic t_refused();
    int s;
    s = starts;
    wok(`OTP_IDX_IRQ_EN, 8'h02);
    wok(`OTP_IDX_CTRL, 8'h01);
    rdx(`OTP_IDX_IRQ_ST, 8'h02, "refused event");
    check_pins(1'b1);
    wok(`OTP_IDX_IRQ_EN, 8'h00);
    check_pins(1'b0);
    wok(`OTP_IDX_IRQ_CLR, 8'h02);
    rdx(`OTP_IDX_IRQ_ST, 8'h00, "event cleared");
    unlock(`OTP_KEY1_CODE ^ 32'h0000_0100, `OTP_KEY2_CODE);
    rdx(`OTP_IDX_KEY1D, 8'h00, "key reads zero");
    wok(`OTP_IDX_CTRL, 8'h01);
    @(negedge i_mclk);
    chk("starts", s, starts);
    wok(`OTP_IDX_IRQ_CLR, 8'h02);
  endtask : t_refused

  task automatic t_prog(input logic page);
    int s;
    s = starts;
    unlock(`OTP_KEY1_CODE, `OTP_KEY2_CODE);
    wok(`OTP_IDX_CTRL, {6'h00, page, 1'b1});
    @(negedge i_mclk);
    chk("starts", s + 1, starts);
    chk("page", {31'h0, page}, {31'h0, o_prog_page});
    rdx(`OTP_IDX_CTRL, {6'h00, page, 1'b1}, "ctrl busy");
    @(posedge i_mclk);
    i_prog_done <= 1'b1;
    @(posedge i_mclk);
    i_prog_done <= 1'b0;
    rdx(`OTP_IDX_CTRL, {6'h00, page, 1'b0}, "ctrl ready");
    rdx(`OTP_IDX_IRQ_ST, 8'h01, "done event");
    wok(`OTP_IDX_IRQ_CLR, 8'h01);
  endtask : t_prog

  task automatic t_ecc();
    // equal bytes keep the check byte free of byte-order assumptions
    for (int i = 0; i < 8; i++) wok(`OTP_IDX_DIN1 + 12'(i), 8'hA5);
    wok(`OTP_IDX_TEST, 8'h03);
    for (int i = 0; i < 8; i++) begin
      rdx(`OTP_IDX_DOUT1 + 12'(i), 8'hA5, "enc");
    end
    rdx(`OTP_IDX_DOUT9, enc9(DATA), "enc check");
    wok(`OTP_IDX_DIN1, 8'hA4);
    wok(`OTP_IDX_DIN9, enc9(DATA));
    wok(`OTP_IDX_TEST, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rdx(`OTP_IDX_DOUT1 + 12'(i), 8'hA5, "dec");
    end
    rdx(`OTP_IDX_IRQ_ST, 8'h04, "sec flag");
    // a second flipped bit makes a double error; class 1 flags it
    wok(`OTP_IDX_DIN1 + 12'h001, 8'hA4);
    wok(`OTP_IDX_TEST, 8'h09);
    wok(`OTP_IDX_IRQ_CLR, 8'h04);
    rdx(`OTP_IDX_IRQ_ST, 8'h08, "ded flag");
    wok(`OTP_IDX_TEST, 8'h00);
    wok(`OTP_IDX_IRQ_CLR, 8'h08);
    rdx(`OTP_IDX_IRQ_ST, 8'h00, "flags cleared");
    wok(`OTP_IDX_DIN1 + 12'h001, 8'h00);
    rdx(`OTP_IDX_DOUT1 + 12'h001, 8'hA4, "dout held");
    @(posedge i_mclk);
    i_otp_word <= {enc9(DATA), DATA ^ 64'h0000_0000_0000_0010};
    i_otp_valid <= 1'b1;
    @(posedge i_mclk);
    i_otp_valid <= 1'b0;
    @(negedge i_mclk);
    chk("otp data lo", DATA[31:0], o_otp_data[31:0]);
    chk("otp data hi", DATA[63:32], o_otp_data[63:32]);
  endtask : t_ecc

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // roughly 330 cycles are needed; the limit leaves ample margin
  initial begin
    #400_000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_reset();
    t_unmapped();
    t_refused();
    t_prog(1'b0);
    t_prog(1'b1);
    t_ecc();
    wrap_up();
  end
endmodule : tb_otp_prog_ecc
